// File: src/wdu_pkg.sv
// wdu_pkg: register map, field positions, reset values and timing counts of the watchdog unit
package wdu_pkg;
	// ==========================================
	// register byte addresses
	localparam logic [11:0] WDU_START_ADDR = 12'h000;
	localparam logic [11:0] WDU_CTRL_ADDR = 12'h004;
	localparam logic [11:0] WDU_MODE_ONE_ADDR = 12'h008;
	localparam logic [11:0] WDU_MODE_TWO_ADDR = 12'h00C;
	localparam logic [11:0] WDU_PROTECT_ADDR = 12'h010;
	localparam logic [11:0] WDU_CLKCTL_ADDR = 12'h014;
	localparam logic [11:0] WDU_STATUS_ADDR = 12'h018;
	// ==========================================
	// field positions
	localparam int WDU_RATIO_BIT = 7;
	localparam int WDU_SUBCLK_BIT = 0;
	localparam int WDU_RESET_SEL_BIT = 2;
	localparam int WDU_SRC_SEL_BIT = 2;
	localparam int WDU_WREN_BIT = 1;
	localparam int WDU_STOP_BIT = 0;
	// ==========================================
	// reset values and counts
	localparam logic [14:0] WDU_FULL_COUNT = 15'h7FFF;
	localparam logic [6:0] WDU_DIV_16_TOP = 7'h0F;
	localparam logic [6:0] WDU_DIV_128_TOP = 7'h7F;
	localparam logic [6:0] WDU_DIV_2_TOP = 7'h01;
	localparam logic [2:0] WDU_NMI_LEVEL = 3'h7;
	localparam logic [31:0] WDU_ZERO_WORD = 32'h0000_0000;
	typedef enum logic [1:0] {WDU_IDLE, WDU_RUN} wdu_state_t;
endpackage : wdu_pkg

// File: src/wdu_prescaler.sv
// wdu_prescaler: divides the cpu clock into count pulses for the watchdog counter
`timescale 1ns/1ps
module wdu_prescaler (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// control
	input wire logic run_i,
	input wire logic clear_i,
	input wire logic [6:0] top_i,
	// pulse out
	output logic tick_o
);
	import wdu_pkg::*;
	logic [6:0] count;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			count <= 7'h00;
			tick_o <= 1'b0;
		end else if (ce_i) begin
			tick_o <= 1'b0;
			if (clear_i) begin
				count <= 7'h00;
			end else if (run_i) begin
				if (count >= top_i) begin
					count <= 7'h00;
					tick_o <= 1'b1;
				end else begin
					count <= count + 7'h01;
				end
			end
		end
	end
endmodule : wdu_prescaler

// File: src/wdu_top.sv
// wdu_top: watchdog timer unit with apb register access
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
module wdu_top (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// system state pins
	input wire logic stop_mode_i,
	input wire logic wait_mode_i,
	input wire logic hold_state_i,
	input wire logic ring_osc_clk_i,
	input wire logic irq_accept_i,
	// outputs
	output logic wdt_irq_o,
	output logic wdt_reset_o,
	output logic ring_osc_en_o,
	output logic stop_request_o,
	output logic [2:0] ipl_o
);
	import wdu_pkg::*;
	// ==========================================
	// registers
	wdu_state_t state;
	logic [14:0] counter;
	logic prescaler_ratio_select;
	logic sub_clock_select;
	logic underflow_reset_select;
	logic count_source_select;
	logic mode_write_enable;
	logic all_clock_stop_bit;
	logic [2:0] ring_sync;
	logic [2:0] stop_sync;
	logic [2:0] wait_sync;
	logic [2:0] hold_sync;
	logic [1:0] acc_sync;
	logic acc_prev;
	logic tick;
	logic ring_edge;
	logic freeze;
	logic pre_run;
	logic step;
	logic [6:0] div_top;
	logic wr_en;
	logic rd_en;
	logic start_wr;
	logic [31:0] next_rdata;
	logic next_err;
	// ==========================================
	// apb decode
	function automatic logic addr_known(input logic [11:0] a);
		addr_known = (a == WDU_START_ADDR) || (a == WDU_CTRL_ADDR) || (a == WDU_MODE_ONE_ADDR) ||
			(a == WDU_MODE_TWO_ADDR) || (a == WDU_PROTECT_ADDR) || (a == WDU_CLKCTL_ADDR) ||
			(a == WDU_STATUS_ADDR);
	endfunction : addr_known
	assign wr_en = psel_i && penable_i && pwrite_i && ce_i;
	assign rd_en = psel_i && penable_i && !pwrite_i && ce_i;
	assign start_wr = wr_en && (paddr_i == WDU_START_ADDR);
	// ==========================================
	// pin synchronisers
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ring_sync <= 3'h0;
			stop_sync <= 3'h0;
			wait_sync <= 3'h0;
			hold_sync <= 3'h0;
			acc_sync <= 2'h0;
			acc_prev <= 1'b0;
		end else if (ce_i) begin
			ring_sync <= {ring_sync[1:0], ring_osc_clk_i};
			stop_sync <= {stop_sync[1:0], stop_mode_i};
			wait_sync <= {wait_sync[1:0], wait_mode_i};
			hold_sync <= {hold_sync[1:0], hold_state_i};
			acc_sync <= {acc_sync[0], irq_accept_i};
			acc_prev <= acc_sync[1];
		end
	end
	// edge taken between second and third stage only
	assign ring_edge = ring_sync[1] && !ring_sync[2];
	// ==========================================
	// count source selection
	always_comb begin
		if (sub_clock_select) begin
			div_top = WDU_DIV_2_TOP;
		end else if (prescaler_ratio_select) begin
			div_top = WDU_DIV_128_TOP;
		end else begin
			div_top = WDU_DIV_16_TOP;
		end
	end
	// stop always freezes; wait and hold only without ring source
	assign freeze = stop_sync[2] || (!count_source_select && (wait_sync[2] || hold_sync[2]));
	assign pre_run = (state == WDU_RUN) && !freeze && !count_source_select;
	assign step = (state == WDU_RUN) && !freeze && (count_source_select ? ring_edge : tick);
	wdu_prescaler u_prescaler (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.run_i(pre_run),
		.clear_i(start_wr),
		.top_i(div_top),
		.tick_o(tick)
	);
	// ==========================================
	// counter and underflow
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= WDU_IDLE;
			counter <= WDU_FULL_COUNT;
			wdt_irq_o <= 1'b0;
			wdt_reset_o <= 1'b0;
		end else if (ce_i) begin
			wdt_irq_o <= 1'b0;
			if (start_wr) begin
				state <= WDU_RUN;
				counter <= WDU_FULL_COUNT;
			end else if (step) begin
				// 32768 steps from full count to underflow
				if (counter == 15'h0000) begin
					counter <= WDU_FULL_COUNT;
					if (underflow_reset_select) begin
						wdt_reset_o <= 1'b1;
					end else begin
						wdt_irq_o <= 1'b1;
					end
				end else begin
					counter <= counter - 15'h0001;
				end
			end
		end
	end
	// ==========================================
	// control registers
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			prescaler_ratio_select <= 1'b0;
			sub_clock_select <= 1'b0;
			underflow_reset_select <= 1'b0;
			count_source_select <= 1'b0;
			mode_write_enable <= 1'b0;
			all_clock_stop_bit <= 1'b0;
		end else if (wr_en) begin
			if (paddr_i == WDU_CTRL_ADDR) begin
				prescaler_ratio_select <= pwdata_i[WDU_RATIO_BIT];
				sub_clock_select <= pwdata_i[WDU_SUBCLK_BIT];
			end else if (paddr_i == WDU_MODE_ONE_ADDR) begin
				if (mode_write_enable && pwdata_i[WDU_RESET_SEL_BIT]) begin
					underflow_reset_select <= 1'b1;
				end
			end else if (paddr_i == WDU_MODE_TWO_ADDR) begin
				if (mode_write_enable) begin
					count_source_select <= pwdata_i[WDU_SRC_SEL_BIT];
				end
			end else if (paddr_i == WDU_PROTECT_ADDR) begin
				mode_write_enable <= pwdata_i[WDU_WREN_BIT];
			end else if (paddr_i == WDU_CLKCTL_ADDR) begin
				if (!count_source_select) begin
					all_clock_stop_bit <= pwdata_i[WDU_STOP_BIT];
				end
			end
		end
	end
	// ==========================================
	// side outputs
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ring_osc_en_o <= 1'b0;
			stop_request_o <= 1'b0;
			ipl_o <= 3'h0;
		end else if (ce_i) begin
			ring_osc_en_o <= count_source_select;
			stop_request_o <= all_clock_stop_bit && !count_source_select;
			if (acc_sync[1] && !acc_prev) begin
				ipl_o <= WDU_NMI_LEVEL;
			end
		end
	end
	// ==========================================
	// apb read path
	always_comb begin
		next_rdata = WDU_ZERO_WORD;
		next_err = !addr_known(paddr_i);
		if (paddr_i == WDU_CTRL_ADDR) begin
			next_rdata[WDU_RATIO_BIT] = prescaler_ratio_select;
			next_rdata[WDU_SUBCLK_BIT] = sub_clock_select;
		end else if (paddr_i == WDU_MODE_ONE_ADDR) begin
			next_rdata[WDU_RESET_SEL_BIT] = underflow_reset_select;
		end else if (paddr_i == WDU_MODE_TWO_ADDR) begin
			next_rdata[WDU_SRC_SEL_BIT] = count_source_select;
		end else if (paddr_i == WDU_PROTECT_ADDR) begin
			next_rdata[WDU_WREN_BIT] = mode_write_enable;
		end else if (paddr_i == WDU_CLKCTL_ADDR) begin
			next_rdata[WDU_STOP_BIT] = all_clock_stop_bit;
		end else if (paddr_i == WDU_STATUS_ADDR) begin
			next_rdata[14:0] = counter;
			next_rdata[16] = (state == WDU_RUN);
		end
	end
	// no wait state: ready in the first access cycle
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			prdata_o <= WDU_ZERO_WORD;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end else if (ce_i) begin
			pready_o <= psel_i && !penable_i;
			pslverr_o <= psel_i && !penable_i && next_err;
			if (psel_i && !penable_i && !pwrite_i) begin
				prdata_o <= next_rdata;
			end
		end
	end
endmodule : wdu_top

// File: verification/wdu_checker.sv
// wdu_checker: port-level assertions for the watchdog unit
`timescale 1ns/1ps
module wdu_checker
	import wdu_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// apb
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic pready_o,
	// system
	input wire logic stop_mode_i,
	input wire logic irq_accept_i,
	input wire logic wdt_irq_o,
	input wire logic wdt_reset_o,
	input wire logic ring_osc_en_o,
	input wire logic stop_request_o,
	input wire logic [2:0] ipl_o
);
	// ====
	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire logic wr = psel_i && penable_i && pwrite_i;
	sequence s_quiet;
		!wdt_irq_o [*8];
	endsequence
	a_irq_spacing: assert property (wdt_irq_o |=> s_quiet) else $error("irq repeated too soon");
	a_start_reload: assert property (wr && paddr_i == WDU_START_ADDR |-> ##2 s_quiet)
		else $error("irq right after start write");
	a_reset_sticky: assert property (wdt_reset_o |=> wdt_reset_o) else $error("reset dropped");
	a_reset_no_irq: assert property (wdt_reset_o |-> !wdt_irq_o) else $error("irq in reset mode");
	a_ipl_on_accept: assert property ($rose(irq_accept_i) |-> ##[1:8] ipl_o == WDU_NMI_LEVEL)
		else $error("level not raised");
	a_ipl_stays: assert property (ipl_o == WDU_NMI_LEVEL |=> $stable(ipl_o)) else $error("level lost");
	a_stop_blocked: assert property (ring_osc_en_o && wr && paddr_i == WDU_CLKCTL_ADDR && !stop_request_o
		|=> !stop_request_o) else $error("stop accepted with ring source");
	a_freeze_stop: assert property (stop_mode_i [*6] |-> !wdt_irq_o) else $error("counting while stopped");
	a_ready_setup: assert property (psel_i && !penable_i |=> pready_o) else $error("ready late");
endmodule : wdu_checker
bind wdu_top wdu_checker wdu_checker_i (.*);

// File: verification/wdu_top_tb.sv
// wdu_top_tb: self-checking bench for the watchdog unit
`timescale 1ns/1ps
module wdu_top_tb;
	import wdu_pkg::*;
	typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e; logic s;} wdu_row_t;
	logic clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, stop_mode_i = 0, irq_accept_i = 0;
	logic [11:0] paddr_i = 0;
	logic [31:0] pwdata_i = 0, prdata_o, rd, s1, s2;
	logic pready_o, pslverr_o, wdt_irq_o, wdt_reset_o, ring_osc_en_o, stop_request_o, sl;
	logic [2:0] ipl_o;
	int miscompares = 0, checks_done = 0, cyc = 0, t0;
	wdu_row_t rows [6] = '{
		'{1, WDU_MODE_ONE_ADDR, 4, 0, 0}, '{0, WDU_MODE_ONE_ADDR, 0, 0, 0},
		'{0, 12'hFFC, 0, 0, 1}, '{1, WDU_PROTECT_ADDR, 2, 0, 0},
		'{0, WDU_PROTECT_ADDR, 0, 2, 0}, '{1, WDU_CTRL_ADDR, 1, 0, 0}};
	wdu_top wdu_top_i (.*, .ce_i(1'b1), .wait_mode_i(1'b0), .hold_state_i(1'b0), .ring_osc_clk_i(1'b0));
	always #20 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 80000) begin
			miscompares++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	// request held until pready is seen high at a rising edge; data taken at that edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
		@(posedge clk_i);
		penable_i <= 1;
		@(posedge clk_i);
		while (pready_o !== 1'b1) @(posedge clk_i);
		rd = prdata_o;
		sl = pslverr_o;
		{psel_i, penable_i} <= 2'b00;
	endtask : apb
	// let registered side outputs follow a completed write
	task automatic settle();
		repeat (2) @(posedge clk_i);
	endtask : settle
	task automatic tally_and_finish();
		if (miscompares == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		apb(0, WDU_STATUS_ADDR, 0);
		s1 = rd;
		repeat (10) @(posedge clk_i);
		apb(0, WDU_STATUS_ADDR, 0);
		chk(rd, s1);
		chk(rd[16], 0);
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) chk(rd, rows[i].e);
			chk(sl, rows[i].s);
		end
		apb(1, WDU_START_ADDR, 32'h1234_5678);
		apb(0, WDU_STATUS_ADDR, 0);
		chk(rd, 32'h0001_7FFF);
		stop_mode_i <= 1;
		repeat (4) @(posedge clk_i);
		apb(0, WDU_STATUS_ADDR, 0);
		s1 = rd;
		repeat (20) @(posedge clk_i);
		apb(0, WDU_STATUS_ADDR, 0);
		chk(rd, s1);
		stop_mode_i <= 0;
		repeat (10) @(posedge clk_i);
		apb(0, WDU_STATUS_ADDR, 0);
		chk(32'(rd[14:0] < s1[14:0]), 1);
		apb(1, WDU_CLKCTL_ADDR, 1);
		settle();
		chk(stop_request_o, 1);
		apb(1, WDU_CLKCTL_ADDR, 0);
		apb(1, WDU_START_ADDR, 0);
		t0 = cyc;
		while (wdt_irq_o !== 1'b1) @(negedge clk_i);
		chk(32'((cyc - t0) inside {[65530:65542]}), 1);
		chk(wdt_reset_o, 0);
		irq_accept_i <= 1;
		repeat (10) @(posedge clk_i);
		chk(ipl_o, WDU_NMI_LEVEL);
		apb(1, WDU_MODE_ONE_ADDR, 4);
		apb(1, WDU_MODE_ONE_ADDR, 0);
		apb(0, WDU_MODE_ONE_ADDR, 0);
		chk(rd, 4);
		apb(1, WDU_MODE_TWO_ADDR, 4);
		settle();
		chk(ring_osc_en_o, 1);
		apb(1, WDU_CLKCTL_ADDR, 1);
		settle();
		chk(stop_request_o, 0);
		apb(1, WDU_PROTECT_ADDR, 0);
		apb(1, WDU_MODE_TWO_ADDR, 0);
		apb(0, WDU_MODE_TWO_ADDR, 0);
		chk(rd, 4);
		apb(1, WDU_START_ADDR, 0);
		chk(sl, 0);
		tally_and_finish();
	end
endmodule : wdu_top_tb
